/* File: bit_timing_select.sv */
`timescale 1ns/100ps
module bit_timing_select (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       enable_in,
   input  wire logic [7:0] prescaler_in,
   output logic [8:0]      tq_divider_out,
   output logic [3:0]      sample_tq_out,
   output logic [2:0]      sjw_out
);
   typedef struct packed {
      logic [8:0] div;
      logic [3:0] sample;
      logic [2:0] sjw;
   } timing_state_type;

   timing_state_type s_reg;
   timing_state_type s_next;

   always_comb begin
      s_next = s_reg;
      // Ten quanta per bit, so bit rate = clock / (10 * (psc + 1))
      s_next.div = {1'b0, prescaler_in} + 9'h001;
      // Only the smallest prescaler reaches the fastest rates
      if (prescaler_in == loader_pkg::FAST_PSC_LIMIT) begin
         s_next.sample = loader_pkg::SAMPLE_TQ_FAST;
         s_next.sjw = loader_pkg::SJW_FAST;
      end else begin
         s_next.sample = loader_pkg::SAMPLE_TQ_SLOW;
         s_next.sjw = loader_pkg::SJW_SLOW;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_reg <= '0;
      end else if (enable_in) begin
         s_reg <= s_next;
      end
   end

   assign tq_divider_out = s_reg.div;
   assign sample_tq_out = s_reg.sample;
   assign sjw_out = s_reg.sjw;
endmodule

/* File: can_node_eeprom_init_loader.sv */
// Functional notes
// - Node id bits 0..6 come from low id byte; its bit 0 ignored.
// - Node id bits 7..9 come from high id byte.
// - Direction bit forced: 0 for transmit id, 1 for receive id.
// - Global receive id from its own byte pair, direction bit forced to 1.
// - Words 0x00..0x08 hold marks, ids, registers, config and prescaler.
// - Mixed mark 0x55 selects mixed mode with strap low id bits.
// - Mixed mode samples id bits 1..3 from the strap pins.
// - Mixed mode forces id bit 0 low; that pin is chip select.
// - Mixed mode takes id bits 4..9 from the EEPROM.
// - Bit rate is clock divided by ten times prescaler plus one.
// - Prescaler is loaded only during initialization.
// - Pin mode bit rate fixed at clock divided by 40.
// - Sample point 60% up to 500 kbit/s, 80% at 1 Mbit/s.
// - Jump width 4 quanta up to 500 kbit/s, 2 at 1 Mbit/s.
// - Configuration accepted only when first location reads 0xAA.
// - Chip select held low before reading the EEPROM.
// - Status message is sent before normal communication starts.
`timescale 1ns/100ps
module can_node_eeprom_init_loader (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        enable_in,
   input  wire logic        eeprom_mode_in,
   input  wire logic [3:0]  id_pins_in,
   input  wire logic        status_sent_in,
   output logic             id_cs_out,
   output logic             id_cs_oe_n_out,
   output logic             id_sk_out,
   output logic             id_sk_oe_n_out,
   output logic             id_di_out,
   output logic             id_di_oe_n_out,
   output logic             mixed_strap_mode_out,
   output logic             config_loaded_out,
   output logic [10:0]      tx_id_out,
   output logic [10:0]      rx_id_out,
   output logic [10:0]      global_rx_id_out,
   output logic             global_id_valid_out,
   output logic [7:0]       rising_edge_config_out,
   output logic [7:0]       falling_edge_config_out,
   output logic [7:0]       port_low_output_latch_out,
   output logic [7:0]       port_high_output_latch_out,
   output logic [7:0]       port_low_direction_out,
   output logic [7:0]       port_high_direction_out,
   output logic [7:0]       pwm_low_byte_out,
   output logic [7:0]       pwm_high_byte_out,
   output logic [7:0]       analog_out_control_out,
   output logic [7:0]       comparator_config_out,
   output logic [7:0]       general_config_reg_out,
   output logic [7:0]       bit_rate_prescaler_out,
   output logic [8:0]       tq_divider_out,
   output logic [3:0]       sample_tq_out,
   output logic [2:0]       sjw_out,
   output logic             status_request_out,
   output logic             init_done_out
);
   typedef struct packed {
      loader_pkg::load_state_type state;
      logic [7:0]  wait_count;
      logic [5:0]  addr;
      logic        start;
      logic        valid;
      logic        mixed;
      logic [9:0]  node_id;
      logic [9:0]  global_id;
      logic        global_valid;
      logic [7:0]  rise_edge;
      logic [7:0]  fall_edge;
      logic [7:0]  out_low;
      logic [7:0]  out_high;
      logic [7:0]  dir_low;
      logic [7:0]  dir_high;
      logic [7:0]  pwm_high;
      logic [7:0]  pwm_low;
      logic [7:0]  analog_ctrl;
      logic [7:0]  comp_cfg;
      logic [7:0]  gen_cfg;
      logic [7:0]  prescaler;
      logic        status_req;
      logic        done;
   } loader_state_type;

   loader_state_type s_reg;
   loader_state_type s_next;

   serial_if link ();

   logic        miso;
   logic        cs_drive;
   logic        sk_drive;
   logic        di_drive;

   // EEPROM data output shares id pin 3
   assign miso = id_pins_in[3];

   serial_word_reader reader (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .enable_in  (enable_in),
      .rd         (link),
      .data_in    (miso),
      .select_out (cs_drive),
      .sclk_out   (sk_drive),
      .cmd_out    (di_drive)
   );

   bit_timing_select timing (
      .clk_in         (clk_in),
      .reset_in       (reset_in),
      .enable_in      (enable_in),
      .prescaler_in   (s_reg.prescaler),
      .tq_divider_out (tq_divider_out),
      .sample_tq_out  (sample_tq_out),
      .sjw_out        (sjw_out)
   );

   assign link.start = s_reg.start;
   assign link.addr = s_reg.addr;

   // Strap pins are read only with cs low
   always_comb begin
      s_next = s_reg;
      s_next.start = 1'b0;

      case (s_reg.state)
         loader_pkg::ST_IDLE: begin
            if (eeprom_mode_in) begin
               s_next.wait_count = 8'h00;
               s_next.addr = loader_pkg::WORD_MARKS;
               s_next.state = loader_pkg::ST_CSLOW;
            end else begin
               // Pin mode: strap id, fixed rate, defaults kept
               s_next.node_id = {loader_pkg::PIN_ID_UPPER, id_pins_in};
               s_next.prescaler = loader_pkg::PIN_PRESCALER;
               s_next.state = loader_pkg::ST_STATUS;
            end
         end

         loader_pkg::ST_CSLOW: begin
            // Quiet the shared serial bus before the first command
            if (s_reg.wait_count == 8'(loader_pkg::CS_IDLE_CYCLES - 1)) begin
               s_next.start = 1'b1;
               s_next.state = loader_pkg::ST_CMD;
            end else begin
               s_next.wait_count = s_reg.wait_count + 8'h01;
            end
         end

         loader_pkg::ST_CMD: begin
            if (link.busy) begin
               s_next.state = loader_pkg::ST_DATA;
            end
         end

         loader_pkg::ST_DATA: begin
            if (link.done) begin
               s_next.state = loader_pkg::ST_STORE;
            end
         end

         loader_pkg::ST_STORE: begin
            s_next.state = loader_pkg::ST_CMD;
            s_next.start = 1'b1;
            s_next.addr = s_reg.addr + 6'h01;
            case (s_reg.addr)
               loader_pkg::WORD_MARKS: begin
                  if (link.word[15:8] == loader_pkg::VALID_MARK) begin
                     s_next.valid = 1'b1;
                     s_next.mixed = (link.word[7:0] == loader_pkg::MIXED_MARK);
                  end else begin
                     // Foreign EEPROM: behave as pin mode
                     s_next.node_id = {loader_pkg::PIN_ID_UPPER, id_pins_in};
                     s_next.prescaler = loader_pkg::PIN_PRESCALER;
                     s_next.start = 1'b0;
                     s_next.state = loader_pkg::ST_STATUS;
                  end
               end

               loader_pkg::WORD_NODE_ID: begin
                  if (s_reg.mixed) begin
                     // Bit 0 is the chip select pin, so only 8 nodes exist
                     s_next.node_id = {link.word[10:8], link.word[7:5],
                                       id_pins_in[3:1], 1'b0};
                  end else begin
                     s_next.node_id = {link.word[10:8], link.word[7:1]};
                  end
               end

               loader_pkg::WORD_GLOBAL_ID: begin
                  s_next.global_id = {link.word[10:8], link.word[7:1]};
                  s_next.global_valid = 1'b1;
               end

               loader_pkg::WORD_EDGE: begin
                  s_next.rise_edge = link.word[15:8];
                  s_next.fall_edge = link.word[7:0];
               end

               loader_pkg::WORD_OUTPUT: begin
                  s_next.out_low = link.word[15:8];
                  s_next.out_high = link.word[7:0];
               end

               loader_pkg::WORD_DIRECTION: begin
                  s_next.dir_low = link.word[15:8];
                  s_next.dir_high = link.word[7:0];
               end

               loader_pkg::WORD_PWM: begin
                  s_next.pwm_high = link.word[15:8];
                  s_next.pwm_low = link.word[7:0];
               end

               loader_pkg::WORD_ANALOG: begin
                  s_next.analog_ctrl = link.word[15:8];
                  s_next.comp_cfg = link.word[7:0];
               end

               default: begin
                  s_next.gen_cfg = link.word[15:8];
                  s_next.prescaler = link.word[7:0];
                  s_next.start = 1'b0;
                  s_next.state = loader_pkg::ST_STATUS;
               end
            endcase
         end

         loader_pkg::ST_STATUS: begin
            s_next.status_req = 1'b1;
            if (s_reg.status_req && status_sent_in) begin
               s_next.status_req = 1'b0;
               s_next.done = 1'b1;
               s_next.state = loader_pkg::ST_DONE;
            end
         end

         loader_pkg::ST_DONE: begin
            // Held until the next reset
            s_next.done = 1'b1;
         end

         default: begin
            s_next.state = loader_pkg::ST_IDLE;
         end
      endcase
   end

   // Reset defaults are the pin-mode values
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_reg <= '0;
         s_reg.state <= loader_pkg::ST_IDLE;
         s_reg.rise_edge <= loader_pkg::EDGE_RESET;
         s_reg.fall_edge <= loader_pkg::EDGE_RESET;
         s_reg.out_low <= loader_pkg::OUT_LATCH_RESET;
         s_reg.out_high <= loader_pkg::OUT_LATCH_RESET;
         s_reg.dir_low <= loader_pkg::DIR_RESET;
         s_reg.dir_high <= loader_pkg::DIR_RESET;
         s_reg.pwm_low <= loader_pkg::PWM_RESET;
         s_reg.pwm_high <= loader_pkg::PWM_RESET;
         s_reg.analog_ctrl <= loader_pkg::CTRL_RESET;
         s_reg.comp_cfg <= loader_pkg::CTRL_RESET;
         s_reg.gen_cfg <= loader_pkg::CTRL_RESET;
         s_reg.prescaler <= loader_pkg::PIN_PRESCALER;
      end else if (enable_in) begin
         s_reg <= s_next;
      end
   end

   // Serial pins are driven only in EEPROM mode; chip select low when idle
   assign id_cs_out = cs_drive;
   assign id_cs_oe_n_out = ~eeprom_mode_in;

   assign id_sk_out = sk_drive;
   assign id_sk_oe_n_out = ~eeprom_mode_in;
   assign id_di_out = di_drive;
   assign id_di_oe_n_out = ~eeprom_mode_in;

   assign mixed_strap_mode_out = s_reg.mixed;
   assign config_loaded_out = s_reg.valid;
   assign tx_id_out = {s_reg.node_id, 1'b0};
   assign rx_id_out = {s_reg.node_id, 1'b1};
   assign global_rx_id_out = {s_reg.global_id, 1'b1};
   assign global_id_valid_out = s_reg.global_valid;

   assign rising_edge_config_out = s_reg.rise_edge;
   assign falling_edge_config_out = s_reg.fall_edge;

   assign port_low_output_latch_out = s_reg.out_low;
   assign port_high_output_latch_out = s_reg.out_high;
   assign port_low_direction_out = s_reg.dir_low;
   assign port_high_direction_out = s_reg.dir_high;

   assign pwm_low_byte_out = s_reg.pwm_low;
   assign pwm_high_byte_out = s_reg.pwm_high;
   assign analog_out_control_out = s_reg.analog_ctrl;
   assign comparator_config_out = s_reg.comp_cfg;
   assign general_config_reg_out = s_reg.gen_cfg;

   assign bit_rate_prescaler_out = s_reg.prescaler;
   assign status_request_out = s_reg.status_req;
   assign init_done_out = s_reg.done;
endmodule

/* File: can_node_eeprom_init_loader_tb.sv */
`timescale 1ns/100ps
module can_node_eeprom_init_loader_tb;
   logic             clk_in = 1'b0;
   logic             reset_in = 1'b1;
   logic             enable_in = 1'b1;
   logic             eeprom_mode_in = 1'b0;
   logic             status_sent_in = 1'b0;
   logic [3:0]       strap = 4'h0;
   logic [8:0][15:0] words = '0;
   logic [3:0]       id_pins_in;
   logic             do_line;
   logic [7:0]       reads;
   logic             id_cs_out, id_cs_oe_n_out, id_sk_out, id_sk_oe_n_out, id_di_out;
   logic             id_di_oe_n_out, mixed_strap_mode_out, config_loaded_out;
   logic             global_id_valid_out, status_request_out, init_done_out;
   logic [10:0]      tx_id_out, rx_id_out, global_rx_id_out;
   logic [7:0]       rising_edge_config_out, falling_edge_config_out;
   logic [7:0]       port_low_output_latch_out, port_high_output_latch_out;
   logic [7:0]       port_low_direction_out, port_high_direction_out;
   logic [7:0]       pwm_low_byte_out, pwm_high_byte_out, analog_out_control_out;
   logic [7:0]       comparator_config_out, general_config_reg_out, bit_rate_prescaler_out;
   logic [8:0]       tq_divider_out;
   logic [3:0]       sample_tq_out;
   logic [2:0]       sjw_out;
   int               bad_count = 0;
   int               samples_checked = 0;
   int               cycles = 0;

   can_node_eeprom_init_loader dut (
      .clk_in, .reset_in, .enable_in, .eeprom_mode_in, .id_pins_in, .status_sent_in,
      .id_cs_out, .id_cs_oe_n_out, .id_sk_out, .id_sk_oe_n_out, .id_di_out, .id_di_oe_n_out,
      .mixed_strap_mode_out, .config_loaded_out, .tx_id_out, .rx_id_out, .global_rx_id_out,
      .global_id_valid_out, .rising_edge_config_out, .falling_edge_config_out,
      .port_low_output_latch_out, .port_high_output_latch_out, .port_low_direction_out,
      .port_high_direction_out, .pwm_low_byte_out, .pwm_high_byte_out,
      .analog_out_control_out, .comparator_config_out, .general_config_reg_out,
      .bit_rate_prescaler_out, .tq_divider_out, .sample_tq_out, .sjw_out,
      .status_request_out, .init_done_out
   );
   eeprom_model partner (.reset_in, .cs_in(id_cs_out), .sk_in(id_sk_out), .di_in(id_di_out),
      .words_in(words), .do_out(do_line), .reads_out(reads));

   // Pulls hold the strap levels whenever nothing drives a pin
   assign id_pins_in = {id_cs_out ? do_line : strap[3], strap[2:1],
                        id_cs_oe_n_out ? strap[0] : id_cs_out};

   always #12.5 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [9:0] node_id(input logic [15:0] w, input logic mix,
                                          input logic [3:0] p);
      return mix ? {w[10:8], w[7:5], p[3:1], 1'b0} : {w[10:8], w[7:1]};
   endfunction

   task automatic scenario(input logic mode, input logic [3:0] p, input logic [8:0][15:0] w);
      int         n;
      logic       ok;
      logic       mix;
      logic [9:0] id;
      logic [7:0] psc;
      ok = mode && w[0][15:8] == 8'hAA;
      mix = ok && w[0][7:0] == 8'h55;
      id = ok ? node_id(w[1], mix, p) : {loader_pkg::PIN_ID_UPPER, p[3:1], mode ? 1'b0 : p[0]};
      psc = ok ? w[8][7:0] : 8'h03;
      @(negedge clk_in);
      reset_in = 1'b1;
      eeprom_mode_in = mode;
      strap = p;
      words = w;
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      n = 0;
      while (status_request_out !== 1'b1 && n < 25000) begin
         @(negedge clk_in);
         n++;
      end
      chk("request_before_done", 16'h0002, {status_request_out, init_done_out});
      status_sent_in = 1'b1;
      @(negedge clk_in);
      status_sent_in = 1'b0;
      chk("done_after_status", 16'h0002, {init_done_out, status_request_out});
      repeat (3) @(negedge clk_in);
      chk("config_loaded", {15'h0000, ok}, {15'h0000, config_loaded_out});
      chk("mixed_mode", {15'h0000, mix}, {15'h0000, mixed_strap_mode_out});
      chk("tx_id", {id, 1'b0}, tx_id_out);
      chk("rx_id", {id, 1'b1}, rx_id_out);
      chk("global_id", {ok, ok ? node_id(w[2], 1'b0, p) : 10'h000, 1'b1},
          {global_id_valid_out, global_rx_id_out});
      chk("edges", ok ? w[3] : 16'h0000, {rising_edge_config_out, falling_edge_config_out});
      chk("latch", ok ? w[4] : 16'hFFFF,
          {port_low_output_latch_out, port_high_output_latch_out});
      chk("dir", ok ? w[5] : 16'h0000, {port_low_direction_out, port_high_direction_out});
      chk("pwm", ok ? w[6] : 16'h0000, {pwm_high_byte_out, pwm_low_byte_out});
      chk("analog", ok ? w[7] : 16'h0000, {analog_out_control_out, comparator_config_out});
      chk("cfg_psc", {ok ? w[8][15:8] : 8'h00, psc},
          {general_config_reg_out, bit_rate_prescaler_out});
      chk("tq_div", psc + 9'h001, tq_divider_out);
      chk("timing", psc == 8'h00 ? 16'h0082 : 16'h0064,
          {8'h00, sample_tq_out, 1'b0, sjw_out});
      chk("reads", ok ? 16'h0009 : {15'h0000, mode}, reads);
      chk("oe_n", {3{~mode}}, {id_cs_oe_n_out, id_sk_oe_n_out, id_di_oe_n_out});
   endtask

   initial begin
      logic [8:0][15:0] w;
      int               seed;
      seed = $urandom(21);
      for (int i = 0; i < 9; i++) w[i] = 16'($urandom);
      scenario(1'b0, 4'($urandom), w);
      w[0] = 16'hAA00;
      w[8][7:0] = 8'($urandom_range(255, 1));
      scenario(1'b1, 4'($urandom), w);
      for (int i = 1; i < 8; i++) w[i] = 16'($urandom);
      w[0] = 16'hAA55;
      w[8] = {8'($urandom), 8'h00};
      scenario(1'b1, 4'($urandom), w);
      // Mixed mark present but valid mark one bit off
      w[0] = 16'hAB55;
      scenario(1'b1, 4'($urandom), w);
      conclude();
   end
endmodule

/* File: eeprom_model.sv */
`timescale 1ns/100ps
module eeprom_model (
   input  wire logic             reset_in,
   input  wire logic             cs_in,
   input  wire logic             sk_in,
   input  wire logic             di_in,
   input  wire logic [8:0][15:0] words_in,
   output logic                  do_out,
   output logic [7:0]            reads_out
);
   int         bits = 0;
   logic [8:0] cmd = 9'h000;
   initial {do_out, reads_out} = 9'h000;
   always @(posedge cs_in) bits = 0;
   // Counts only reads that arrive in address order with the read opcode
   always @(posedge sk_in or posedge reset_in) begin
      if (reset_in) reads_out = 8'h00;
      else if (cs_in) begin
         if (bits < 9) cmd = {cmd[7:0], di_in};
         bits = bits + 1;
         if (bits == 9 && cmd == {loader_pkg::READ_OPCODE, reads_out[5:0]})
            reads_out = reads_out + 8'h01;
      end
   end
   // New bit on SK fall so it is steady at the next rise; stale data is inverted
   always @(negedge sk_in or negedge cs_in) begin
      if (cs_in && bits >= 9 && bits < 25 && cmd[5:0] < 6'h09)
         do_out = words_in[cmd[5:0]][24 - bits];
      else do_out = ~do_out;
   end
endmodule

/* File: loader_checker_asserts.sv */
`timescale 1ns/100ps
module loader_checker (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic [3:0]  id_pins_in,
   input wire logic        status_sent_in,
   input wire logic        id_cs_out,
   input wire logic        id_sk_out,
   input wire logic        id_di_out,
   input wire logic        mixed_strap_mode_out,
   input wire logic        config_loaded_out,
   input wire logic [10:0] tx_id_out,
   input wire logic [10:0] rx_id_out,
   input wire logic [7:0]  bit_rate_prescaler_out,
   input wire logic [8:0]  tq_divider_out,
   input wire logic [3:0]  sample_tq_out,
   input wire logic [2:0]  sjw_out,
   input wire logic        status_request_out,
   input wire logic        init_done_out
);
   logic [7:0] age_reg;
   logic       cs_seen_reg;
   // Saturating age; cs_seen_reg holds only the first select after reset to the wait
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         age_reg     <= 8'h00;
         cs_seen_reg <= 1'b0;
      end else begin
         if (age_reg != 8'hFF) age_reg <= age_reg + 8'h01;
         if (id_cs_out) cs_seen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence start_bit_s;
      id_di_out && !id_sk_out ##[1:41] $rose(id_sk_out) && id_di_out;
   endsequence
   sequence handshake_s;
      status_request_out && status_sent_in;
   endsequence
   AST_CS_IDLE: assert property ($rose(id_cs_out) && !cs_seen_reg |-> age_reg >= 8'h50)
      else $error("chip select rose before the idle wait");
   AST_WORD_START: assert property ($rose(id_cs_out) |-> start_bit_s)
      else $error("read command did not open with a start bit");
   AST_DIR_BITS: assert property (init_done_out |->
      tx_id_out == {rx_id_out[10:1], 1'b0} && rx_id_out[0]) else $error("direction bits wrong");
   AST_MIXED_LOW: assert property (init_done_out && mixed_strap_mode_out |->
      tx_id_out[4:1] == {id_pins_in[3:1], 1'b0}) else $error("mixed low id bits wrong");
   AST_MIXED_VALID: assert property (mixed_strap_mode_out |-> config_loaded_out)
      else $error("mixed mode without valid mark");
   AST_PIN_RATE: assert property (init_done_out && !config_loaded_out |->
      bit_rate_prescaler_out == 8'h03) else $error("pin mode prescaler wrong");
   AST_TQ_DIV: assert property (init_done_out |->
      tq_divider_out == {1'b0, bit_rate_prescaler_out} + 9'h001) else $error("divider wrong");
   AST_TIMING: assert property (init_done_out |-> (bit_rate_prescaler_out == 8'h00) ?
      (sample_tq_out == 4'h8 && sjw_out == 3'h2) : (sample_tq_out == 4'h6 && sjw_out == 3'h4))
      else $error("bit timing segments wrong");
   AST_PSC_HELD: assert property (init_done_out |=> $stable(bit_rate_prescaler_out))
      else $error("prescaler changed after init");
   AST_STATUS: assert property (handshake_s |=> init_done_out && !status_request_out)
      else $error("status handshake did not finish init");
   AST_DONE_CAUSE: assert property ($rose(init_done_out) |-> $past(status_request_out))
      else $error("init done without status request");
endmodule

bind can_node_eeprom_init_loader loader_checker rule_watch (
   .clk_in, .reset_in, .id_pins_in, .status_sent_in, .id_cs_out, .id_sk_out, .id_di_out,
   .mixed_strap_mode_out, .config_loaded_out, .tx_id_out, .rx_id_out,
   .bit_rate_prescaler_out, .tq_divider_out, .sample_tq_out, .sjw_out,
   .status_request_out, .init_done_out
);

/* File: loader_pkg.sv */
package loader_pkg;
   // EEPROM word map
   localparam logic [5:0] WORD_MARKS       = 6'h00;
   localparam logic [5:0] WORD_NODE_ID     = 6'h01;
   localparam logic [5:0] WORD_GLOBAL_ID   = 6'h02;
   localparam logic [5:0] WORD_EDGE        = 6'h03;
   localparam logic [5:0] WORD_OUTPUT      = 6'h04;
   localparam logic [5:0] WORD_DIRECTION   = 6'h05;
   localparam logic [5:0] WORD_PWM         = 6'h06;
   localparam logic [5:0] WORD_ANALOG      = 6'h07;
   localparam logic [5:0] WORD_CONFIG      = 6'h08;
   localparam logic [5:0] WORD_LAST        = 6'h08;
   localparam logic [7:0] VALID_MARK       = 8'h00AA;
   localparam logic [7:0] MIXED_MARK       = 8'h0055;
   // Serial read command: start bit, read opcode 10
   localparam logic [2:0] READ_OPCODE      = 3'h6;
   localparam int         CMD_BITS         = 9;
   localparam int         DATA_BITS        = 16;
   // Serial clock half period
   localparam int         SK_HALF_NS       = 1000;
   localparam int         CLK_NS           = 25;
   localparam int         SK_HALF_CYCLES   = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
   // Chip select held low before first read
   localparam int         CS_IDLE_NS       = 2000;
   localparam int         CS_IDLE_CYCLES   = (CS_IDLE_NS + CLK_NS - 1) / CLK_NS;
   // Register defaults
   localparam logic [7:0] EDGE_RESET       = 8'h0000;
   localparam logic [7:0] OUT_LATCH_RESET  = 8'h00FF;
   localparam logic [7:0] DIR_RESET        = 8'h0000;
   localparam logic [7:0] PWM_RESET        = 8'h0000;
   localparam logic [7:0] CTRL_RESET       = 8'h0000;
   // Pin-mode identifier upper bits (6 bits, ID9..ID4)
   localparam logic [5:0] PIN_ID_UPPER     = 6'h20;
   // Pin mode divides by 40 = 10 * (3 + 1)
   localparam logic [7:0] PIN_PRESCALER    = 8'h0003;
   localparam int         TQ_PER_PSC       = 10;
   // Bit timing (time quanta of ten per bit)
   localparam logic [3:0] SAMPLE_TQ_SLOW   = 4'h6;
   localparam logic [3:0] SAMPLE_TQ_FAST   = 4'h8;
   localparam logic [2:0] SJW_SLOW         = 3'h4;
   localparam logic [2:0] SJW_FAST         = 3'h2;
   localparam logic [7:0] FAST_PSC_LIMIT   = 8'h0000;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'b000_0001,
      ST_CSLOW  = 7'b000_0010,
      ST_CMD    = 7'b000_0100,
      ST_DATA   = 7'b000_1000,
      ST_STORE  = 7'b001_0000,
      ST_STATUS = 7'b010_0000,
      ST_DONE   = 7'b100_0000
   } load_state_type;
endpackage

/* File: serial_if.sv */
`timescale 1ns/100ps
interface serial_if;
   logic        start;
   logic [5:0]  addr;
   logic        busy;
   logic        done;
   logic [15:0] word;
   modport master (output start, output addr, input busy, input done, input word);
   modport reader (input start, input addr, output busy, output done, output word);
endinterface

/* File: serial_word_reader.sv */
`timescale 1ns/100ps
module serial_word_reader (
   input  wire logic   clk_in,
   input  wire logic   reset_in,
   input  wire logic   enable_in,
   serial_if.reader    rd,
   input  wire logic   data_in,
   output logic        select_out,
   output logic        sclk_out,
   output logic        cmd_out
);
   typedef struct packed {
      logic        active;
      logic        sk;
      logic [7:0]  div;
      logic [4:0]  count;
      logic        phase_data;
      logic [8:0]  shift_out;
      logic [15:0] shift_in;
      logic        done;
      logic        cs;
   } reader_state_type;

   reader_state_type s_reg;
   reader_state_type s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (!s_reg.active) begin
         if (rd.start) begin
            s_next.active = 1'b1;
            s_next.cs = 1'b1;
            s_next.sk = 1'b0;
            s_next.div = 8'h00;
            s_next.count = 5'h00;
            s_next.phase_data = 1'b0;
            s_next.shift_out = {loader_pkg::READ_OPCODE, rd.addr};
         end
      end else if (s_reg.div == 8'(loader_pkg::SK_HALF_CYCLES - 1)) begin
         s_next.div = 8'h00;
         s_next.sk = ~s_reg.sk;
         if (s_reg.sk) begin
            // Falling edge: shift to next command bit, or end after the last data bit
            if (!s_reg.phase_data) begin
               s_next.shift_out = {s_reg.shift_out[7:0], 1'b0};
               if (s_reg.count == 5'(loader_pkg::CMD_BITS - 1)) begin
                  s_next.phase_data = 1'b1;
                  s_next.count = 5'h00;
               end else begin
                  s_next.count = s_reg.count + 5'h01;
               end
            end else if (s_reg.count == 5'(loader_pkg::DATA_BITS)) begin
               s_next.active = 1'b0;
               s_next.cs = 1'b0;
               s_next.sk = 1'b0;
               s_next.done = 1'b1;
            end
         end else if (s_reg.phase_data) begin
            // Rising edge: sample data, MSB first
            s_next.shift_in = {s_reg.shift_in[14:0], data_in};
            s_next.count = s_reg.count + 5'h01;
         end
      end else begin
         s_next.div = s_reg.div + 8'h01;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_reg <= '0;
      end else if (enable_in) begin
         s_reg <= s_next;
      end
   end

   assign rd.busy = s_reg.active;
   assign rd.done = s_reg.done;
   assign rd.word = s_reg.shift_in;
   assign select_out = s_reg.cs;
   assign sclk_out = s_reg.sk;
   assign cmd_out = s_reg.shift_out[8];
endmodule
